// *** isfc_pkg.sv ***
// constants and types shared by the identification and scratch register bank
package isfc_pkg;
   // register word addresses on the serial link (even byte of each pair)
   localparam logic [6:0] ADDR_GLOBAL_CMD = 7'h68;
   localparam logic [6:0] ADDR_MONTH_DAY = 7'h6e;
   localparam logic [6:0] ADDR_YEAR = 7'h70;
   localparam logic [6:0] ADDR_PRODUCT = 7'h72;
   localparam logic [6:0] ADDR_SERIAL = 7'h74;
   localparam logic [6:0] ADDR_SCRATCH_A = 7'h76;
   localparam logic [6:0] ADDR_SCRATCH_B = 7'h78;
   localparam logic [6:0] ADDR_SCRATCH_C = 7'h7a;
   localparam logic [6:0] ADDR_WRITES_LOW = 7'h7c;
   localparam logic [6:0] ADDR_WRITES_HIGH = 7'h7e;

   // frame layout: write flag, 7-bit address, 8-bit data
   localparam int FRAME_BITS = 16;
   localparam int WRITE_FLAG_BIT = 15;
   localparam int CMD_FLASH_UPDATE_BIT = 3;
   localparam int SCRATCH_WORDS = 3;

   // factory contents; product code value is arbitrary
   localparam logic [15:0] DEF_PRODUCT_CODE = 16'h5a3c;
   localparam logic [15:0] DEF_MONTH_DAY = 16'h0101;
   localparam logic [15:0] DEF_YEAR = 16'h2000;
   localparam logic [15:0] DEF_SERIAL = 16'h0001;
   localparam logic [15:0] SCRATCH_RESET = 16'h0000;
   localparam logic [31:0] WRITES_RESET = 32'h0000_0000;

   // flash update busy time
   localparam int CLK_HZ = 20_000_000;
   localparam int FLASH_UPDATE_US = 1000;
   localparam int FLASH_UPDATE_CYCLES = FLASH_UPDATE_US * (CLK_HZ / 1_000_000);

   typedef enum logic {ISFC_IDLE, ISFC_BUSY} isfc_state_t;
endpackage

// *** isfc_link_if.sv ***
// frame hand-off between the serial shifter and the register bank
`timescale 1ns/10ps
interface isfc_link_if;
   logic frame_valid;
   logic [15:0] frame_word;
   logic [15:0] tx_word;
   modport link (output frame_valid, output frame_word, input tx_word);
   modport bank (input frame_valid, input frame_word, output tx_word);
endinterface

// *** isfc_spi_frame.sv ***
// serial shifter: 16-bit frames in, response word out, clock idles high
`timescale 1ns/10ps
module isfc_spi_frame
   import isfc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   isfc_link_if.link lk
);
   logic sclk_q, next_sclk_q;
   logic cs_q, next_cs_q;
   logic [15:0] rx, next_rx;
   logic [15:0] tx, next_tx;
   logic [4:0] count, next_count;
   logic next_dout;
   logic valid, next_valid;
   logic [15:0] word, next_word;
   logic rise, fall, start;

   // pin edge detection, pins already synchronous
   assign rise = sclk & ~sclk_q & ~cs_n;
   assign fall = ~sclk & sclk_q & ~cs_n;
   assign start = ~cs_n & cs_q;

   // shift in on rising edge, shift out on falling edge
   always_comb begin
      next_sclk_q = sclk;
      next_cs_q = cs_n;
      next_rx = rx;
      next_tx = tx;
      next_count = count;
      next_dout = dout;
      next_valid = 1'b0;
      next_word = word;
      if (cs_n) begin
         next_count = 5'h00;
      end
      if (start) begin
         next_tx = lk.tx_word;
         next_dout = lk.tx_word[15];
      end else if (fall) begin
         // each fall puts out the current msb, so the first fall drives bit 15
         next_tx = {tx[14:0], 1'b0};
         next_dout = tx[15];
      end
      if (rise) begin
         next_rx = {rx[14:0], din};
         if (count == 5'(FRAME_BITS - 1)) begin
            next_valid = 1'b1;
            next_word = {rx[14:0], din};
            next_count = 5'h00;
         end else begin
            next_count = count + 5'h01;
         end
      end
   end

   // shifter state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b1;
         cs_q <= 1'b1;
         rx <= 16'h0000;
         tx <= 16'h0000;
         count <= 5'h00;
         dout <= 1'b0;
         valid <= 1'b0;
         word <= 16'h0000;
      end else begin
         sclk_q <= next_sclk_q;
         cs_q <= next_cs_q;
         rx <= next_rx;
         tx <= next_tx;
         count <= next_count;
         dout <= next_dout;
         valid <= next_valid;
         word <= next_word;
      end
   end

   assign lk.frame_valid = valid;
   assign lk.frame_word = word;
endmodule

// *** isfc_regs.sv ***
// identification, scratch and flash write counter register bank
`timescale 1ns/10ps

module isfc_regs
   import isfc_pkg::*;
#(
   parameter int UPDATE_CYCLES = FLASH_UPDATE_CYCLES,
   parameter logic [15:0] PRODUCT_CODE = DEF_PRODUCT_CODE,
   parameter logic [15:0] MONTH_DAY = DEF_MONTH_DAY,
   parameter logic [15:0] YEAR = DEF_YEAR,
   parameter logic [15:0] SERIAL = DEF_SERIAL
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   output logic cmd_busy
);
   isfc_link_if lk ();

   logic [15:0] scratch [SCRATCH_WORDS];
   logic [15:0] next_scratch [SCRATCH_WORDS];
   logic [15:0] image [SCRATCH_WORDS];
   logic [15:0] next_image [SCRATCH_WORDS];
   logic [31:0] writes, next_writes;
   isfc_state_t state, next_state;
   logic [19:0] cnt, next_cnt;
   logic [15:0] tx, next_tx;
   logic next_busy;
   logic take, is_write;
   logic [6:0] addr;
   logic [7:0] data;
   logic [1:0] slot;

   // serial frame shifter
   isfc_spi_frame u_frame (
      .clk(clk),
      .rst(rst),
      .sclk(sclk),
      .cs_n(cs_n),
      .din(din),
      .dout(dout),
      .lk(lk)
   );

   // scratch slot of an address, 3 when not a scratch word
   function automatic logic [1:0] scratch_slot(input logic [6:0] a);
      logic [6:0] even;
      even = {a[6:1], 1'b0};
      if (even == ADDR_SCRATCH_A) begin
         scratch_slot = 2'h0;
      end else if (even == ADDR_SCRATCH_B) begin
         scratch_slot = 2'h1;
      end else if (even == ADDR_SCRATCH_C) begin
         scratch_slot = 2'h2;
      end else begin
         scratch_slot = 2'h3;
      end
   endfunction

   // read data of an address; unmapped words read as zero
   function automatic logic [15:0] read_word(input logic [6:0] a);
      logic [6:0] even;
      even = {a[6:1], 1'b0};
      if (even == ADDR_MONTH_DAY) begin
         read_word = MONTH_DAY;
      end else if (even == ADDR_YEAR) begin
         read_word = YEAR;
      end else if (even == ADDR_PRODUCT) begin
         read_word = PRODUCT_CODE;
      end else if (even == ADDR_SERIAL) begin
         read_word = SERIAL;
      end else if (even == ADDR_SCRATCH_A) begin
         read_word = scratch[0];
      end else if (even == ADDR_SCRATCH_B) begin
         read_word = scratch[1];
      end else if (even == ADDR_SCRATCH_C) begin
         read_word = scratch[2];
      end else if (even == ADDR_WRITES_LOW) begin
         read_word = writes[15:0];
      end else if (even == ADDR_WRITES_HIGH) begin
         read_word = writes[31:16];
      end else begin
         read_word = 16'h0000;
      end
   endfunction

   // frame fields; frames count only while idle
   assign take = lk.frame_valid && (state == ISFC_IDLE);
   assign is_write = lk.frame_word[WRITE_FLAG_BIT];
   assign addr = lk.frame_word[14:8];
   assign data = lk.frame_word[7:0];
   assign slot = scratch_slot(addr);

   // register writes, reads, flash update sequencing
   always_comb begin
      next_scratch = scratch;
      next_image = image;
      next_writes = writes;
      next_state = state;
      next_cnt = cnt;
      next_tx = tx;
      case (state)
         ISFC_IDLE: begin
            if (take && is_write) begin
               if (slot != 2'h3) begin
                  if (addr[0]) begin
                     next_scratch[slot][15:8] = data;
                  end else begin
                     next_scratch[slot][7:0] = data;
                  end
               end else if (addr == ADDR_GLOBAL_CMD && data[CMD_FLASH_UPDATE_BIT]) begin
                  next_image = scratch;
                  next_writes = writes + 32'h0000_0001;
                  next_state = ISFC_BUSY;
                  next_cnt = 20'(UPDATE_CYCLES - 1);
                  next_tx = 16'h0000;
               end
               // other addresses hold read-only words: nothing changes
            end else if (take) begin
               next_tx = read_word(addr);
            end
         end
         ISFC_BUSY: begin
            if (cnt == 20'h00000) begin
               next_state = ISFC_IDLE;
            end else begin
               next_cnt = cnt - 20'h00001;
            end
         end
         default: begin
            next_state = ISFC_IDLE;
         end
      endcase
      next_busy = (next_state == ISFC_BUSY);
   end

   // bank state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < SCRATCH_WORDS; i++) begin
            scratch[i] <= SCRATCH_RESET;
            image[i] <= SCRATCH_RESET;
         end
         writes <= WRITES_RESET;
         state <= ISFC_IDLE;
         cnt <= 20'h00000;
         tx <= 16'h0000;
         cmd_busy <= 1'b0;
      end else begin
         scratch <= next_scratch;
         image <= next_image;
         writes <= next_writes;
         state <= next_state;
         cnt <= next_cnt;
         tx <= next_tx;
         cmd_busy <= next_busy;
      end
   end

   assign lk.tx_word = tx;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic rd_take;
   assign rd_take = take && !is_write;

   month_byte_a: assert property (rd_take && addr == ADDR_MONTH_DAY |=> tx[15:8] == MONTH_DAY[15:8])
      else $error("month byte wrong");
   day_byte_a: assert property (rd_take && addr == ADDR_MONTH_DAY |=> tx[7:0] == MONTH_DAY[7:0])
      else $error("day byte wrong");
   year_read_a: assert property (rd_take && addr == ADDR_YEAR |=> tx == YEAR)
      else $error("year read wrong");
   product_read_a: assert property (rd_take && addr == ADDR_PRODUCT |=> tx == PRODUCT_CODE)
      else $error("product code read wrong");
   serial_read_a: assert property (rd_take && addr == ADDR_SERIAL |=> tx == SERIAL)
      else $error("serial read wrong");
   scratch_write_a: assert property (take && is_write && addr == ADDR_SCRATCH_B
      |=> scratch[1][7:0] == $past(data) && scratch[0] == $past(scratch[0]))
      else $error("scratch write wrong");
   flash_save_a: assert property (take && is_write && addr == ADDR_GLOBAL_CMD
      && data[CMD_FLASH_UPDATE_BIT] |=> image[2] == $past(scratch[2]) && cmd_busy)
      else $error("flash save wrong");
   count_step_a: assert property (state == ISFC_IDLE && next_state == ISFC_BUSY
      |=> writes == $past(writes) + 32'h0000_0001)
      else $error("write count step wrong");
   count_read_a: assert property (rd_take && addr == ADDR_WRITES_HIGH
      |=> tx == $past(writes[31:16]))
      else $error("count high read wrong");
   busy_ignore_a: assert property (state == ISFC_BUSY ##1 state == ISFC_BUSY
      |-> $stable(scratch[0]) && $stable(tx) && cmd_busy)
      else $error("frame taken while busy");
   ro_write_a: assert property (take && is_write && slot == 2'h3
      && addr != ADDR_GLOBAL_CMD |=> $stable(writes) && $stable(scratch[1]))
      else $error("read-only write changed state");

   // cycles spent in the current flash update, for the busy length checks
   logic [19:0] busy_len, next_busy_len;

   // elapsed busy count, cleared whenever the bank is idle
   always_comb begin
      next_busy_len = 20'h00000;
      if (state == ISFC_BUSY) begin
         next_busy_len = busy_len + 20'h00001;
      end
   end

   // elapsed busy count register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_len <= 20'h00000;
      end else begin
         busy_len <= next_busy_len;
      end
   end

   // even byte of a scratch word leaves the odd byte alone
   scratch_low_a: assert property (take && is_write && addr == ADDR_SCRATCH_A
      |=> scratch[0][7:0] == $past(data) && scratch[0][15:8] == $past(scratch[0][15:8]))
      else $error("scratch low byte wrong");
   // odd byte of a scratch word leaves the even byte alone
   scratch_high_a: assert property (take && is_write
      && addr == (ADDR_SCRATCH_C | 7'h01)
      |=> scratch[2][15:8] == $past(data) && scratch[2][7:0] == $past(scratch[2][7:0]))
      else $error("scratch high byte wrong");
   // a scratch read hands back the stored word
   scratch_read_a: assert property (rd_take && addr == ADDR_SCRATCH_B
      |=> tx == $past(scratch[1]))
      else $error("scratch read wrong");
   // a finished frame is applied once only
   frame_once_a: assert property (lk.frame_valid
      |=> !lk.frame_valid)
      else $error("frame strobe too long");

   // the saved image holds scratch words 0 and 1 at the update (word 2 is checked in flash_save_a)
   image_copy_a: assert property (state == ISFC_IDLE && next_state == ISFC_BUSY
      |=> image[0] == $past(scratch[0]) && image[1] == $past(scratch[1]))
      else $error("image copy wrong");
   // the saved image moves only on an update command
   image_hold_a: assert property (!(state == ISFC_IDLE && next_state == ISFC_BUSY)
      |=> $stable(image[0]) && $stable(image[1]) && $stable(image[2]))
      else $error("image changed without update");

   // low word of the write count reads back as stored
   count_low_read_a: assert property (rd_take && addr == ADDR_WRITES_LOW
      |=> tx == $past(writes[15:0]))
      else $error("count low read wrong");
   // the write count moves only when an update starts
   count_hold_a: assert property (!(state == ISFC_IDLE && next_state == ISFC_BUSY)
      |=> $stable(writes))
      else $error("write count moved without update");

   // the busy output follows the update state
   busy_out_a: assert property (cmd_busy == (state == ISFC_BUSY))
      else $error("busy output wrong");
   // an update never outlasts its time
   busy_len_a: assert property (state == ISFC_BUSY
      |-> busy_len < 20'(UPDATE_CYCLES))
      else $error("update too long");
   // the down counter matches the elapsed time
   cnt_range_a: assert property (state == ISFC_BUSY
      |-> cnt == 20'(UPDATE_CYCLES - 1) - busy_len)
      else $error("update counter wrong");
   // the update ends after exactly its time
   busy_end_a: assert property (state == ISFC_BUSY
      && busy_len == 20'(UPDATE_CYCLES - 1) |=> state == ISFC_IDLE && !cmd_busy)
      else $error("update did not end");
   // frames that finish during an update change nothing
   busy_frame_a: assert property (lk.frame_valid && state == ISFC_BUSY
      |=> $stable(scratch[1]) && $stable(scratch[2]) && $stable(writes))
      else $error("frame applied while busy");
   // the reply word is cleared when an update starts
   reply_clear_a: assert property (state == ISFC_IDLE && next_state == ISFC_BUSY
      |=> tx == 16'h0000)
      else $error("reply not cleared on update");

   // scratch writes leave the pending reply alone
   write_reply_a: assert property (take && is_write && slot != 2'h3
      |=> $stable(tx))
      else $error("write disturbed reply");
   // writes to read-only words touch no stored word
   ro_other_a: assert property (take && is_write && slot == 2'h3
      && addr != ADDR_GLOBAL_CMD
      |=> $stable(scratch[0]) && $stable(scratch[2]) && $stable(image[0]) && $stable(tx))
      else $error("read-only write changed a word");

   update_cv: cover property (state == ISFC_IDLE ##1 state == ISFC_BUSY);
   busy_end_cv: cover property (state == ISFC_BUSY ##1 state == ISFC_IDLE);
   scratch_rd_cv: cover property (rd_take && addr == ADDR_SCRATCH_C);
   drop_cv: cover property (lk.frame_valid && state == ISFC_BUSY);
   ro_write_cv: cover property (take && is_write && slot == 2'h3 && addr != ADDR_GLOBAL_CMD);
endmodule

// *** isfc_host.sv ***
// serial host model that sends frames to the register bank and gathers replies
`timescale 1ns/10ps
module isfc_host (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   // each serial clock level is held for three system clocks
   task automatic pause(input int n);
      repeat (n) @(negedge clk);
   endtask

   // one 16-bit frame, msb first; the reply bit is taken just before each rise
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_n = 1'b0;
      pause(3);
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0;
         din = tx[i];
         pause(3);
         rx[i] = dout;
         sclk = 1'b1;
         pause(3);
      end
      cs_n = 1'b1;
      din = ~din; // a released line must not keep showing the last bit
      pause(4); // gap lets the bank load the next reply
   endtask

   // idle levels: clock high, device deselected
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end
endmodule

// *** tb_top.sv ***
// self-checking bench for the identification and scratch register bank
`timescale 1ns/10ps
module tb_top
   import isfc_pkg::*;
;
   localparam int UPD = 300; // long enough to drop two frames while busy
   localparam logic [15:0] PCODE = 16'h3c5a; // arbitrary value
   localparam logic [15:0] MDAY = 16'h1127;
   localparam logic [15:0] YR = 16'h2017;
   localparam logic [15:0] SER = 16'h0456;
   logic clk, rst, sclk, cs_n, din, dout, cmd_busy;
   logic [15:0] rx;
   int bad_count = 0;
   int samples_checked = 0;
   logic [6:0] sa [3] = '{ADDR_SCRATCH_A, ADDR_SCRATCH_B, ADDR_SCRATCH_C};
   logic [15:0] sv [3] = '{16'ha55a, 16'h0ff0, 16'hc3e1};
   logic [6:0] ra [6] = '{ADDR_PRODUCT, ADDR_YEAR, ADDR_SERIAL, ADDR_MONTH_DAY,
      ADDR_WRITES_LOW, ADDR_WRITES_HIGH};
   logic [15:0] re [6] = '{PCODE, YR, SER, MDAY, 16'h0000, 16'h0000};

   isfc_regs #(.UPDATE_CYCLES(UPD), .PRODUCT_CODE(PCODE), .MONTH_DAY(MDAY), .YEAR(YR),
      .SERIAL(SER)) dut_u (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .cmd_busy(cmd_busy));
   isfc_host host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   // 50 ns system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // compare one 16-bit result
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // compare one flag
   task automatic check_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // read a word: the reply arrives in the following frame
   task automatic rd(input string name, input logic [6:0] a, input logic [15:0] exp);
      host_u.xfer({1'b0, a, 8'h00}, rx);
      host_u.xfer({1'b0, ADDR_PRODUCT, 8'h00}, rx);
      check(name, exp, rx);
   endtask

   // write a word as high byte at the odd address, then low byte at the even one
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      host_u.xfer({1'b1, a | 7'h01, v[7:0] ^ v[7:0] ^ v[15:8]}, rx);
      host_u.xfer({1'b1, a, v[7:0]}, rx);
   endtask

   // flash update: frame during busy is dropped, then wait for busy to end
   task automatic flash_update();
      host_u.xfer(16'he808, rx);
      check_bit("busy", 1'b1, cmd_busy);
      host_u.xfer(16'he900, rx);
      host_u.xfer({1'b1, ADDR_SCRATCH_A, 8'h77}, rx);
      for (int n = 0; n < 1000 && cmd_busy !== 1'b0; n++)
         @(negedge clk);
      if (cmd_busy !== 1'b0) begin
         bad_count++;
         stop_test();
      end
   endtask

   // hang guard
   initial begin
      #(50 * 60000);
      bad_count++;
      stop_test();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      rd("scratch_reset", ADDR_SCRATCH_A, SCRATCH_RESET);
      // writes to read-only words are ignored
      for (int i = 0; i < 6; i++)
         wr(ra[i], ~re[i]);
      for (int i = 0; i < 6; i++)
         rd("read_only", ra[i], re[i]);
      // scratch words written back to back, then read
      for (int i = 0; i < 3; i++)
         wr(sa[i], sv[i]);
      for (int i = 0; i < 3; i++)
         rd("scratch", sa[i], sv[i]);
      rd("unmapped", 7'h40, 16'h0000);
      // looping read of the product code
      host_u.xfer({1'b0, ADDR_PRODUCT, 8'h00}, rx);
      for (int i = 0; i < 3; i++) begin
         host_u.xfer({1'b0, ADDR_PRODUCT, 8'h00}, rx);
         check("product_loop", PCODE, rx);
      end
      // two flash updates: count steps by one, scratch kept, busy frame ignored
      flash_update();
      rd("count_one", ADDR_WRITES_LOW, 16'h0001);
      rd("scratch_kept", ADDR_SCRATCH_A, sv[0]);
      flash_update();
      rd("count_two", ADDR_WRITES_LOW, 16'h0002);
      rd("count_high", ADDR_WRITES_HIGH, 16'h0000);
      stop_test();
   end
endmodule
